/* src/tbc_pkg.sv */
/*
 * tbc_pkg: register map, field positions, codes and reset values of the
 * timer time base with counter clock selection.
 * assumes: one 32-bit apb word per register, byte addressed.
 */
package tbc_pkg;

    // register byte offsets
    localparam int unsigned TBC_AW       = 8;
    localparam logic [7:0]  TBC_OFF_CTRL = 8'h00;
    localparam logic [7:0]  TBC_OFF_SMC  = 8'h04;
    localparam logic [7:0]  TBC_OFF_FLAG = 8'h08;
    localparam logic [7:0]  TBC_OFF_EGR  = 8'h0C;
    localparam logic [7:0]  TBC_OFF_CNT  = 8'h10;
    localparam logic [7:0]  TBC_OFF_PSC  = 8'h14;
    localparam logic [7:0]  TBC_OFF_ARR  = 8'h18;
    localparam logic [7:0]  TBC_OFF_CHM  = 8'h1C;
    localparam logic [7:0]  TBC_OFF_CHE  = 8'h20;
    localparam logic [7:0]  TBC_OFF_OPT  = 8'h24;

    // control_reg_one fields
    localparam int TBC_CR_CEN    = 0;
    localparam int TBC_CR_UDIS   = 1;
    localparam int TBC_CR_URS    = 2;
    localparam int TBC_CR_DIR    = 4;
    localparam int TBC_CR_CMS_LO = 5;
    localparam int TBC_CR_ARBE   = 7;
    // slave_mode_control_reg fields
    localparam int TBC_SM_SMS_LO  = 0;
    localparam int TBC_SM_TS_LO   = 4;
    localparam int TBC_SM_ETF_LO  = 8;
    localparam int TBC_SM_ETPS_LO = 12;
    localparam int TBC_SM_ECE     = 14;
    localparam int TBC_SM_ETP     = 15;
    // irq_flag_reg, event_generate_reg
    localparam int TBC_FL_UIF = 0;
    localparam int TBC_FL_TIF = 6;
    localparam int TBC_EG_UG  = 0;
    // channel_mode_reg, channel_enable_reg, option_reg
    localparam int TBC_CM_CC2S_LO = 8;
    localparam int TBC_CM_IC2F_LO = 12;
    localparam int TBC_CE_CC2P    = 5;
    localparam int TBC_OP_SEL_LO  = 0;
    localparam int TBC_OP_MSKEN   = 2;

    // codes
    localparam logic [2:0] TBC_SMS_OFF  = 3'h0;
    localparam logic [2:0] TBC_SMS_EXT1 = 3'h7;
    localparam logic [2:0] TBC_TS_OTHER = 3'h0;
    localparam logic [2:0] TBC_TS_TI2   = 3'h6;
    localparam logic [2:0] TBC_TS_ETRF  = 3'h7;
    localparam logic [1:0] TBC_CC2S_TI2 = 2'h1;
    localparam logic [1:0] TBC_CMS_EDGE = 2'h0;
    localparam logic [1:0] TBC_EXT_PCLK = 2'h0;
    localparam logic [1:0] TBC_EXT_1K   = 2'h1;
    localparam logic [1:0] TBC_EXT_32K  = 2'h2;
    localparam logic [1:0] TBC_EXT_PIN  = 2'h3;

    // reset values
    localparam logic [15:0] TBC_CNT_RST = 16'h0000;
    localparam logic [15:0] TBC_ARR_RST = 16'hFFFF;
    localparam logic [3:0]  TBC_PSC_RST = 4'h0;

    typedef enum logic [1:0] {
        TBC_SRC_INT  = 2'b00,
        TBC_SRC_EXT1 = 2'b01,
        TBC_SRC_EXT2 = 2'b10
    } tbc_src_t;

endpackage

/* src/tbc_timer_base.sv */
/*
 * tbc_timer_base: 16-bit time base (up, down, center-aligned), update event
 * generation, buffered prescaler and auto-reload, and counter clock select
 * (internal, external mode 1 via channel two or trigger, external mode 2).
 * assumes: apb master on core_clk_i; external pins are asynchronous; the
 * slave update request comes from logic on the same clock.
 */
// The APB slave port and the placing of the registers are this design's own decisions.
// Notes on behaviour
// - down mode counts auto-reload to 0, reloads, flags underflow
// - down mode updates on underflow, software generate, slave request
// - update-disable blocks every update source; prescaler shadow keeps value, reload shadow only with reload buffer enabled
// - software generate in down mode reloads counter, clears prescaler
// - request-source bit keeps software generate from setting update flag
// - update sets flag, copies prescaler and auto-reload buffers in the same cycle
// - center mode: up to reload, down to zero, repeat
// - center mode direction bit is hardware owned, writes ignored
// - center mode updates at every overflow and underflow
// - center mode generate restarts counter and prescaler from zero
// - center mode with updates disabled and reload buffer enabled keeps the active reload value
// - center overflow makes new reload active, counter loads it
// - counter clock: internal, channel input, trigger line, other timer
// - slave mode 000 selects internal clock, generate bit self-clears
// - internal clock reaches prescaler once counter enable is set
// - slave mode 111 counts on selected trigger input edges
// - channel two counting: select 01, filter, polarity, trigger 110
// - each mode 1 edge is one prescaler input tick, sets trigger flag
// - external clock enable selects mode 2 on trigger line edges
// - source field picks peripheral clock, 1 kHz, 32 kHz or pin
// - pin source with mask enable is ANDed with the mask pin
// - trigger path has filter, polarity and edge prescaler
// - internal count enable follows counter enable one cycle later
// - prescaler divides by two to the exponent, new at update
// - up mode counts 0 to auto-reload, restarts, flags overflow
// - reload buffer enable: shadow loads always or at update only
`timescale 1ns/1ps
`default_nettype none

module tbc_timer_base #(
    parameter int unsigned CNT_W = 16
) (
    // clock and reset
    input  wire logic                       core_clk_i,
    input  wire logic                       sys_rst_i,
    // apb slave
    input  wire logic                       psel_i,
    input  wire logic                       penable_i,
    input  wire logic                       pwrite_i,
    input  wire logic [tbc_pkg::TBC_AW-1:0] paddr_i,
    input  wire logic [31:0]                pwdata_i,
    output logic      [31:0]                prdata_o,
    output logic                            pready_o,
    output logic                            pslverr_o,
    // external pins and other timer
    input  wire logic                       channel_two_input_i,
    input  wire logic                       external_clock_pin_i,
    input  wire logic                       clock_mask_pin_i,
    input  wire logic                       osc_1k_i,
    input  wire logic                       osc_32k_i,
    input  wire logic                       other_timer_trigger_i,
    // slave mode controller
    input  wire logic                       slave_update_req_i,
    // status
    output logic                            update_event_o,
    output logic                            trigger_event_o,
    output logic      [CNT_W-1:0]           count_o
);
    import tbc_pkg::*;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    logic [7:0]       ctrl;
    logic [15:0]      smc;
    logic [15:0]      chm;
    logic [15:0]      che;
    logic [2:0]       opt;
    logic [3:0]       psc_buf;
    logic [3:0]       psc_shadow;
    logic [CNT_W-1:0] arr_buf;
    logic [CNT_W-1:0] arr_act;
    logic [CNT_W-1:0] cnt;
    logic [15:0]      psc_cnt;
    logic             internal_count_enable;
    logic             uif;
    logic             tif;
    logic [5:0]       sync_a;
    logic [5:0]       sync_b;
    logic [1:0]       flt_q;
    logic [4:0]       flt_cnt [2];
    logic             etrf_q;
    logic             trgi_q;
    logic [2:0]       etps_cnt;

    // apb decode
    wire acc      = psel_i & penable_i;
    wire done     = acc & pready_o;
    wire wr       = done & pwrite_i;
    wire hit_ctrl = paddr_i == TBC_OFF_CTRL;
    wire hit_smc  = paddr_i == TBC_OFF_SMC;
    wire hit_flag = paddr_i == TBC_OFF_FLAG;
    wire hit_egr  = paddr_i == TBC_OFF_EGR;
    wire hit_cnt  = paddr_i == TBC_OFF_CNT;
    wire hit_psc  = paddr_i == TBC_OFF_PSC;
    wire hit_arr  = paddr_i == TBC_OFF_ARR;
    wire hit_chm  = paddr_i == TBC_OFF_CHM;
    wire hit_che  = paddr_i == TBC_OFF_CHE;
    wire hit_opt  = paddr_i == TBC_OFF_OPT;
    wire mapped   = hit_ctrl | hit_smc | hit_flag | hit_egr | hit_cnt |
                    hit_psc | hit_arr | hit_chm | hit_che | hit_opt;

    // generate bit is a strobe, never stored, so it always reads 0
    wire ug_req = wr & hit_egr & pwdata_i[TBC_EG_UG];

    wire [31:0] rd_word =
        hit_ctrl ? {24'h0000_00, ctrl} :
        hit_smc  ? {16'h0000, smc} :
        hit_flag ? {25'h000_0000, tif, 5'h00, uif} :
        hit_cnt  ? {{(32-CNT_W){1'b0}}, cnt} :
        hit_psc  ? {28'h000_0000, psc_buf} :
        hit_arr  ? {{(32-CNT_W){1'b0}}, arr_buf} :
        hit_chm  ? {16'h0000, chm} :
        hit_che  ? {16'h0000, che} :
        hit_opt  ? {29'h0000_0000, opt} : 32'h0000_0000;

    // control fields
    wire       cen    = ctrl[TBC_CR_CEN];
    wire       udis   = ctrl[TBC_CR_UDIS];
    wire       urs    = ctrl[TBC_CR_URS];
    wire       dir    = ctrl[TBC_CR_DIR];
    wire       arbe   = ctrl[TBC_CR_ARBE];
    wire       center = ctrl[TBC_CR_CMS_LO +: 2] != TBC_CMS_EDGE;
    wire [2:0] sms    = smc[TBC_SM_SMS_LO +: 3];
    wire [2:0] ts     = smc[TBC_SM_TS_LO +: 3];
    wire [3:0] etf    = smc[TBC_SM_ETF_LO +: 4];
    wire [1:0] etps   = smc[TBC_SM_ETPS_LO +: 2];
    wire       ece    = smc[TBC_SM_ECE];
    wire       etp    = smc[TBC_SM_ETP];
    wire [1:0] cc2s   = chm[TBC_CM_CC2S_LO +: 2];
    wire [3:0] ic2f   = chm[TBC_CM_IC2F_LO +: 4];
    wire       cc2p   = che[TBC_CE_CC2P];
    wire [1:0] extsel = opt[TBC_OP_SEL_LO +: 2];
    wire       msken  = opt[TBC_OP_MSKEN];

    // mode 2 wins over mode 1; other slave modes fall back to internal
    tbc_src_t clk_src;
    assign clk_src = ece ? TBC_SRC_EXT2 :
                     (sms == TBC_SMS_EXT1) ? TBC_SRC_EXT1 :
                     TBC_SRC_INT;

    // two-flop synchronisers: ch2, pin, mask, 1k, 32k, other timer
    wire [5:0] raw_in = {other_timer_trigger_i, osc_32k_i, osc_1k_i,
                         clock_mask_pin_i, external_clock_pin_i,
                         channel_two_input_i};
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            sync_a <= 6'h00;
            sync_b <= 6'h00;
        end else begin
            sync_a <= raw_in;
            sync_b <= sync_a;
        end
    end

    // trigger line source, gated pin clock
    wire pin_clk = sync_b[1] & (msken ? sync_b[2] : 1'b1);
    wire etr_raw = (extsel == TBC_EXT_PIN) ? pin_clk :
                   (extsel == TBC_EXT_32K) ? sync_b[4] : sync_b[3];

    // sample filters: new level accepted after code+1 agreeing samples
    wire [1:0] flt_in  = {etr_raw, sync_b[0]};
    wire [3:0] flt_thr [2];
    assign flt_thr[0] = ic2f;
    assign flt_thr[1] = etf;
    for (genvar g = 0; g < 2; g++) begin : g_flt
        always_ff @(posedge core_clk_i) begin
            if (sys_rst_i) begin
                flt_q[g]   <= 1'b0;
                flt_cnt[g] <= 5'h00;
            end else if (flt_in[g] == flt_q[g]) begin
                flt_cnt[g] <= 5'h00;
            end else if (flt_cnt[g] >= {1'b0, flt_thr[g]}) begin
                flt_q[g]   <= flt_in[g];
                flt_cnt[g] <= 5'h00;
            end else begin
                flt_cnt[g] <= 5'(flt_cnt[g] + 5'h01);
            end
        end
    end

    // polarity and edges
    wire etrf     = flt_q[1] ^ etp;
    wire ti2fp2   = (cc2s == TBC_CC2S_TI2) & (flt_q[0] ^ cc2p);
    // peripheral clock as source: every cycle is an edge
    wire etr_edge = (extsel == TBC_EXT_PCLK) | (etrf & ~etrf_q);
    wire trgi     = (ts == TBC_TS_TI2)   ? ti2fp2 :
                    (ts == TBC_TS_ETRF)  ? etrf :
                    (ts == TBC_TS_OTHER) ? sync_b[5] : 1'b0;
    wire trg_edge = trgi & ~trgi_q;
    wire [2:0] etps_mask = 3'((4'h1 << etps) - 4'h1);
    wire prescaled_external_trigger_tick = etr_edge & ((etps_cnt & etps_mask) == etps_mask);
    wire ext1_edge = (clk_src == TBC_SRC_EXT1) & trg_edge;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            etrf_q   <= 1'b0;
            trgi_q   <= 1'b0;
            etps_cnt <= 3'h0;
        end else begin
            etrf_q <= etrf;
            trgi_q <= trgi;
            if (etr_edge) begin
                etps_cnt <= 3'(etps_cnt + 3'h1);
            end
        end
    end

    // prescaler
    wire src_tick = (clk_src == TBC_SRC_EXT2) ? prescaled_external_trigger_tick :
                    (clk_src == TBC_SRC_EXT1) ? trg_edge : 1'b1;
    wire [15:0] psc_mask = 16'((17'h0_0001 << psc_shadow) - 17'h0_0001);
    wire psc_done = psc_cnt == psc_mask;
    wire cnt_tick = internal_count_enable & src_tick & psc_done;

    // counter events and update
    wire [CNT_W-1:0] arr_dec = CNT_W'(arr_act - 1'b1);
    wire at_top  = cnt == arr_act;
    wire at_zero = cnt == {CNT_W{1'b0}};
    wire at_one  = cnt == {{(CNT_W-1){1'b0}}, 1'b1};
    wire ovf = cnt_tick & ~dir & (center ? (cnt == arr_dec) : at_top);
    wire unf = cnt_tick & dir & (center ? at_one : at_zero);
    wire init = ug_req | slave_update_req_i;
    wire ev_src = ovf | unf | init;
    wire uev    = ~udis & ev_src;
    // request-source bit hides only software-generated updates
    wire uif_set = uev & (ovf | unf | slave_update_req_i | ~urs);
    wire [CNT_W-1:0] next_arr = (~arbe | uev) ? arr_buf : arr_act;

    logic [CNT_W-1:0] next_cnt;
    logic             next_dir;
    logic [7:0]       next_ctrl;
    always_comb begin
        next_cnt = cnt;
        next_dir = dir;
        if (uev & init) begin
            if (center) begin
                next_cnt = {CNT_W{1'b0}};
                next_dir = 1'b0;
            end else if (dir) begin
                next_cnt = next_arr;
            end else begin
                next_cnt = {CNT_W{1'b0}};
            end
        end else if (wr & hit_cnt) begin
            next_cnt = pwdata_i[CNT_W-1:0];
        end else if (cnt_tick) begin
            if (center) begin
                if (ovf) begin
                    next_cnt = next_arr;
                    next_dir = 1'b1;
                end else if (unf) begin
                    next_cnt = {CNT_W{1'b0}};
                    next_dir = 1'b0;
                end else if (dir) begin
                    next_cnt = CNT_W'(cnt - 1'b1);
                end else begin
                    next_cnt = CNT_W'(cnt + 1'b1);
                end
            end else if (dir) begin
                next_cnt = at_zero ? next_arr : CNT_W'(cnt - 1'b1);
            end else begin
                next_cnt = at_top ? {CNT_W{1'b0}} : CNT_W'(cnt + 1'b1);
            end
        end
        next_ctrl = (wr & hit_ctrl) ? pwdata_i[7:0] : ctrl;
        next_ctrl[TBC_CR_DIR] = (wr & hit_ctrl & ~center) ?
                                pwdata_i[TBC_CR_DIR] : next_dir;
    end

    // registers and time base state
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            ctrl       <= 8'h00;
            smc        <= 16'h0000;
            chm        <= 16'h0000;
            che        <= 16'h0000;
            opt        <= 3'h0;
            psc_buf    <= TBC_PSC_RST;
            psc_shadow <= TBC_PSC_RST;
            arr_buf    <= CNT_W'(TBC_ARR_RST);
            arr_act    <= CNT_W'(TBC_ARR_RST);
            cnt        <= CNT_W'(TBC_CNT_RST);
            psc_cnt    <= 16'h0000;
            internal_count_enable     <= 1'b0;
            uif        <= 1'b0;
            tif        <= 1'b0;
        end else begin
            ctrl   <= next_ctrl;
            cnt    <= next_cnt;
            internal_count_enable <= cen;
            if (wr & hit_smc) smc <= pwdata_i[15:0];
            if (wr & hit_chm) chm <= pwdata_i[15:0];
            if (wr & hit_che) che <= pwdata_i[15:0];
            if (wr & hit_opt) opt <= pwdata_i[2:0];
            if (wr & hit_psc) psc_buf <= pwdata_i[3:0];
            if (wr & hit_arr) arr_buf <= pwdata_i[CNT_W-1:0];
            arr_act <= next_arr;
            if (uev) begin
                psc_shadow <= psc_buf;
            end
            if (uev & init) begin
                psc_cnt <= 16'h0000;
            end else if (internal_count_enable & src_tick) begin
                psc_cnt <= psc_done ? 16'h0000 : 16'(psc_cnt + 16'h0001);
            end
            // set wins over a write-one clear in the same cycle
            uif <= uif_set | (uif & ~(wr & hit_flag & pwdata_i[TBC_FL_UIF]));
            tif <= ext1_edge | (tif & ~(wr & hit_flag & pwdata_i[TBC_FL_TIF]));
        end
    end

    // apb answer: one wait state, data sampled with pready
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            pready_o        <= 1'b0;
            pslverr_o       <= 1'b0;
            prdata_o        <= 32'h0000_0000;
            update_event_o  <= 1'b0;
            trigger_event_o <= 1'b0;
        end else begin
            pready_o        <= acc & ~pready_o;
            pslverr_o       <= acc & ~pready_o & ~mapped;
            update_event_o  <= uev;
            trigger_event_o <= ext1_edge;
            if (acc & ~pready_o) begin
                prdata_o <= (pwrite_i | ~mapped) ? 32'h0000_0000 : rd_word;
            end
        end
    end

    assign count_o = cnt;

    sequence s_center_peak;
        center && !dir && cnt_tick && cnt == arr_dec && !init &&
        !(wr && hit_cnt);
    endsequence
    sequence s_turn_down;
        dir && cnt == $past(next_arr);
    endsequence

    a_down_reload: assert property (
        !center && dir && cnt_tick && at_zero && !init && !(wr && hit_cnt)
        |-> unf ##1 cnt == $past(next_arr))
        else $error("down count did not reload at zero");
    a_udis_block: assert property (
        udis && arbe |-> !uev ##1 arr_act == $past(arr_act) &&
        psc_shadow == $past(psc_shadow))
        else $error("update happened while disabled");
    a_ug_down_clear: assert property (
        ug_req && !udis && !center && dir
        |=> cnt == $past(next_arr) && psc_cnt == 16'h0000)
        else $error("generate did not reload counter");
    a_urs_hides_flag: assert property (
        ug_req && urs && !uif && !ovf && !unf && !slave_update_req_i
        |=> !uif)
        else $error("software update set flag under request source");
    a_uev_shadows: assert property (
        uev |=> psc_shadow == $past(psc_buf) && arr_act == $past(arr_buf)
        && update_event_o)
        else $error("shadows not loaded on update");
    a_center_turn: assert property (
        s_center_peak |-> ovf ##1 s_turn_down)
        else $error("center mode peak turn wrong");
    a_center_uev: assert property (
        center && (ovf || unf) && !udis |=> update_event_o)
        else $error("center mode missed update");
    a_dir_locked: assert property (
        center && wr && hit_ctrl && !cnt_tick && !init |=> dir == $past(dir))
        else $error("direction written in center mode");
    a_cen_delay: assert property (
        !cen ##1 cen |-> !internal_count_enable ##1 internal_count_enable)
        else $error("count enable not one cycle after enable");
    a_up_wrap: assert property (
        !center && !dir && cnt_tick && at_top && !init && !(wr && hit_cnt)
        |-> ovf ##1 at_zero)
        else $error("up count did not wrap");
    a_ext1_flag: assert property (
        ext1_edge |=> tif && trigger_event_o)
        else $error("mode 1 edge did not flag");

endmodule // tbc_timer_base

`default_nettype wire

/* sim/tbc_pin_model.sv */
/*
 * tbc_pin_model: far side of the timer pins; bursts of clean edges.
 * assumes: fire_i rises to start a burst of four pulses on one pin.
 */
`timescale 1ns/1ps
`default_nettype none

module tbc_pin_model (
    // commands from the bench
    input  wire logic       fire_i,
    input  wire logic       use_pin_i,
    input  wire logic       mask_lvl_i,
    // pins
    output logic            ch2_o,
    output logic            clk_pin_o,
    output logic            mask_o,
    output logic            osc_1k_o,
    output logic            osc_32k_o,
    output logic            other_trig_o
);
    assign mask_o = mask_lvl_i;

    // pulses far wider than sync plus filter, so none is lost; the
    // 30 ns offset keeps pin edges away from the clock edges
    initial begin
        ch2_o        = 1'b0;
        clk_pin_o    = 1'b0;
        osc_1k_o     = 1'b0;
        osc_32k_o    = 1'b0;
        other_trig_o = 1'b0;
        forever begin
            @(posedge fire_i);
            #30;
            repeat (4) begin
                #300;
                if (use_pin_i) clk_pin_o = 1'b1; else ch2_o = 1'b1;
                #300;
                clk_pin_o = 1'b0;
                ch2_o     = 1'b0;
            end
        end
    end
endmodule // tbc_pin_model

`default_nettype wire

/* sim/tbc_timer_base_tb.sv */
/*
 * tbc_timer_base_tb: register tests of the time base over apb.
 * assumes: tbc_pkg map; one-wait-state apb slave; pin model beside it.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
    n_fail++; $display("[ERR] %s exp %h got %h", nm, e, g); end end

module tbc_timer_base_tb;
    import tbc_pkg::*;
    logic        clk, rst, psel, pen, pwr, pready, perr, upd, trg;
    logic        fire, use_pin, mlvl, ch2, cpin, msk, o1k, o32k, otr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [15:0] cnt;
    logic        errv, sur;
    int          n_fail, num_checks, base;
    int          n_upd = 0;
    int          n_trg = 0;

    tbc_timer_base dut_u (.core_clk_i(clk), .sys_rst_i(rst),
        .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(perr), .channel_two_input_i(ch2),
        .external_clock_pin_i(cpin), .clock_mask_pin_i(msk),
        .osc_1k_i(o1k), .osc_32k_i(o32k), .other_timer_trigger_i(otr),
        .slave_update_req_i(sur), .update_event_o(upd),
        .trigger_event_o(trg), .count_o(cnt));

    tbc_pin_model pins_u (.fire_i(fire), .use_pin_i(use_pin),
        .mask_lvl_i(mlvl), .ch2_o(ch2), .clk_pin_o(cpin), .mask_o(msk),
        .osc_1k_o(o1k), .osc_32k_o(o32k), .other_trig_o(otr));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // event pulses counted mid-cycle, where they are settled
    always @(negedge clk) begin
        if (upd === 1'b1) n_upd++;
        if (trg === 1'b1) n_trg++;
    end

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // request held until pready is seen high at a rising edge
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) n_fail++;
        rdv  = prdata;
        errv = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic burst(input logic p);
        use_pin <= p;
        fire    <= 1'b1;
        repeat (30) @(posedge clk);
        fire    <= 1'b0;
        repeat (10) @(posedge clk);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        results();
    end

    initial begin
        int n;
        {psel, pen, pwr, fire, use_pin, sur} = '0;
        mlvl = 1'b0; paddr = 8'h00; pwdata = 32'h0000_0000;
        n_fail = 0; num_checks = 0; rst = 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        xfer(1'b0, TBC_OFF_ARR, 0); `CHK("arr_rst", 32'h0000_FFFF, rdv)
        xfer(1'b0, 8'h28, 0);       `CHK("unmapped", 1'b1, errv)
        // down mode: generate reloads from auto-reload, sets flag
        wr(TBC_OFF_CTRL, 32'h0000_0010);
        wr(TBC_OFF_ARR, 32'h0000_0005);
        wr(TBC_OFF_EGR, 32'h0000_0001);
        xfer(1'b0, TBC_OFF_CNT, 0);  `CHK("ug_reload", 32'h5, rdv)
        xfer(1'b0, TBC_OFF_FLAG, 0); `CHK("uif", 1'b1, rdv[0])
        wr(TBC_OFF_FLAG, 32'h0000_0001);
        wr(TBC_OFF_CTRL, 32'h0000_0014);
        wr(TBC_OFF_CNT, 32'h0000_0002);
        wr(TBC_OFF_EGR, 32'h0000_0001);
        xfer(1'b0, TBC_OFF_CNT, 0);  `CHK("urs_cnt", 32'h5, rdv)
        xfer(1'b0, TBC_OFF_FLAG, 0); `CHK("urs_uif", 1'b0, rdv[0])
        wr(TBC_OFF_CTRL, 32'h0000_0012);
        wr(TBC_OFF_CNT, 32'h0000_0002);
        wr(TBC_OFF_EGR, 32'h0000_0001);
        xfer(1'b0, TBC_OFF_CNT, 0);  `CHK("udis", 32'h2, rdv)
        `CHK("udis_upd", 2, n_upd)
        // free run down: zero is followed by the auto-reload value
        wr(TBC_OFF_CTRL, 32'h0000_0011);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (cnt !== 16'h0000 && n < 40);
        @(negedge clk);
        `CHK("underflow", 16'h0005, cnt)
        // external mode 1 on channel two rising edges
        wr(TBC_OFF_CTRL, 32'h0000_0000);
        wr(TBC_OFF_ARR, 32'h0000_00FF);
        wr(TBC_OFF_CHM, 32'h0000_0100);
        wr(TBC_OFF_CHE, 32'h0000_0000);
        wr(TBC_OFF_SMC, 32'h0000_0067);
        wr(TBC_OFF_FLAG, 32'h0000_0041);
        wr(TBC_OFF_CNT, 32'h0000_0000);
        wr(TBC_OFF_CTRL, 32'h0000_0001);
        base = n_trg;
        burst(1'b0);
        xfer(1'b0, TBC_OFF_CNT, 0);  `CHK("ext1", 32'h4, rdv)
        `CHK("ext1_trg", 4, n_trg - base)
        xfer(1'b0, TBC_OFF_FLAG, 0); `CHK("tif", 1'b1, rdv[6])
        // external mode 2 from the pin, every second rising edge
        wr(TBC_OFF_SMC, 32'h0000_5000);
        wr(TBC_OFF_OPT, 32'h0000_0003);
        wr(TBC_OFF_CNT, 32'h0000_0000);
        base = n_trg;
        burst(1'b1);
        xfer(1'b0, TBC_OFF_CNT, 0);  `CHK("ext2", 32'h2, rdv)
        `CHK("ext2_trg", 0, n_trg - base)
        // mask enabled and mask pin low: the gated clock stays quiet
        wr(TBC_OFF_OPT, 32'h0000_0007);
        burst(1'b1);
        xfer(1'b0, TBC_OFF_CNT, 0);  `CHK("masked", 32'h2, rdv)
        // center mode on the internal clock, reload 3: peak 3, floor 0
        wr(TBC_OFF_CTRL, 32'h0000_0020);
        wr(TBC_OFF_SMC, 32'h0000_0000);
        wr(TBC_OFF_ARR, 32'h0000_0003);
        wr(TBC_OFF_CNT, 32'h0000_0002);
        wr(TBC_OFF_CTRL, 32'h0000_0031);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (cnt !== 16'h0003 && n < 40);
        `CHK("center_top", 16'h0003, cnt)
        @(negedge clk);
        `CHK("center_down", 16'h0002, cnt)
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (cnt !== 16'h0000 && n < 40);
        @(negedge clk);
        `CHK("center_up", 16'h0001, cnt)
        // stopped: generate and slave request restart from zero, upward
        wr(TBC_OFF_CTRL, 32'h0000_0020);
        wr(TBC_OFF_CNT, 32'h0000_0002);
        wr(TBC_OFF_EGR, 32'h0000_0001);
        xfer(1'b0, TBC_OFF_CNT, 0);  `CHK("center_ug", 32'h0, rdv)
        xfer(1'b0, TBC_OFF_CTRL, 0); `CHK("center_dir", 32'h20, rdv)
        base = n_upd;
        wr(TBC_OFF_CNT, 32'h0000_0002);
        sur <= 1'b1;
        @(posedge clk);
        sur <= 1'b0;
        xfer(1'b0, TBC_OFF_CNT, 0);  `CHK("slave_cnt", 32'h0, rdv)
        `CHK("slave_upd", 1, n_upd - base)
        results();
    end
endmodule // tbc_timer_base_tb

`default_nettype wire
